/* stic_map.svh */
// register offsets, command bits, status field positions and count limits for the interval counter
`ifndef STIC_MAP_SVH
`define STIC_MAP_SVH
`define STIC_ADDR_W 4
`define STIC_OFF_ADDR 4'h0
`define STIC_OFF_STATUS 4'h1
`define STIC_OFF_COUNT 4'h2
`define STIC_OFF_MODNUM 4'h6
`define STIC_OFF_CMD 4'h8
`define STIC_CMD_CLEAR 0
`define STIC_CMD_DISARM 1
`define STIC_CMD_ARM 2
`define STIC_ST_CLKSEL 16
`define STIC_ST_RATE_LO 17
`define STIC_ST_ARMED 19
`define STIC_ST_COUNTING 20
`define STIC_ST_FULL 21
`define STIC_ST_OVF 22
`define STIC_ST_LATE 23
`define STIC_CNT_MAX 24'h0FFFFF
`define STIC_DIV_TEN 4'h9
`endif

/* stic_pkg.sv */
// types shared by the interval counter
package stic_pkg;
	typedef enum logic [1:0] {STIC_RATE_1, STIC_RATE_10, STIC_RATE_100,
		STIC_RATE_1000} stic_rate_t;
endpackage

/* stic_top.sv */
// serial time interval counter: capture core, clock divider, register port
//
// Overview of operation
// - arm clears counter and pointer and ends any capture
// - first start after arm begins counting; later starts ignored
// - each stop while counting stores count at pointer, then advances
// - capture memory holds 1024 words of 24 bits
// - counter reaching FFFFF ends capture, zeroes counter and pointer
// - after the 1024th store capture ends; no overwrite before arm
// - arm during a count ends it; next start restarts counting
// - disarm command or pin ends capture; needs arm and start again
// - source clock internal or external, chosen by strap input
// - divided rates 1/10, 1/100, 1/1000 chosen by strap input
// - disarmed after reset; no counting until arm then start
// - running counter not readable; only stored on valid stops
// - every implemented command answers x as one
// - first stop goes to address 000, 1024th to 3FF
// - every host read of a stored count advances the pointer
// - address and count access refused with q zero while armed
// - status holds armed, counting, full, overflow, late stop flags
`timescale 1ns/1ps
`default_nettype none
`include "stic_map.svh"
module stic_top
	import stic_pkg::*;
#(
	parameter int DEPTH = 1024,
	parameter int DATA_W = 24,
	parameter int PTR_W = 10,
	parameter logic [11:0] MODULE_ID = 12'h0A5 // arbitrary value
)(
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic [`STIC_ADDR_W-1:0] i_addr,
	input wire logic [23:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [23:0] o_rdata,
	output logic o_q,
	output logic o_x,
	input wire logic i_start,
	input wire logic i_stop,
	input wire logic i_disarm,
	input wire logic i_clk_int,
	input wire logic i_clk_ext,
	input wire logic i_sel_ext,
	input wire logic [1:0] i_rate,
	output logic o_armed,
	output logic o_counting
);
	// start, stop and disarm pins and both count clocks each cross through their own synchroniser
	logic start_ev;
	logic stop_ev;
	logic dis_ev;
	logic cint_ev;
	logic cext_ev;
	stic_sync u_sync_start(
		.i_clk(i_clk_sys),
		.i_reset(i_reset),
		.i_pin(i_start),
		.o_rise(start_ev)
	);
	stic_sync u_sync_stop(
		.i_clk(i_clk_sys),
		.i_reset(i_reset),
		.i_pin(i_stop),
		.o_rise(stop_ev)
	);
	stic_sync u_sync_dis(
		.i_clk(i_clk_sys),
		.i_reset(i_reset),
		.i_pin(i_disarm),
		.o_rise(dis_ev)
	);
	stic_sync u_sync_cint(
		.i_clk(i_clk_sys),
		.i_reset(i_reset),
		.i_pin(i_clk_int),
		.o_rise(cint_ev)
	);
	stic_sync u_sync_cext(
		.i_clk(i_clk_sys),
		.i_reset(i_reset),
		.i_pin(i_clk_ext),
		.o_rise(cext_ev)
	);

	// straps caught by a clocked process, not by the reset
	logic sel_ext_reg;
	logic [1:0] rate_reg;
	always_ff @(posedge i_clk_sys)
	begin
		sel_ext_reg <= i_sel_ext;
		rate_reg <= i_rate;
	end
	wire src_tick = sel_ext_reg ? cext_ev : cint_ev;

	// decade dividers run freely so the rate has no phase per arm
	logic t10;
	logic t100;
	logic t1000;
	stic_decade u_dec0(
		.i_clk(i_clk_sys),
		.i_reset(i_reset),
		.i_tick(src_tick),
		.o_tick(t10)
	);
	stic_decade u_dec1(
		.i_clk(i_clk_sys),
		.i_reset(i_reset),
		.i_tick(t10),
		.o_tick(t100)
	);
	stic_decade u_dec2(
		.i_clk(i_clk_sys),
		.i_reset(i_reset),
		.i_tick(t100),
		.o_tick(t1000)
	);
	logic cnt_tick;
	always_comb
	begin
		case (stic_rate_t'(rate_reg))
			STIC_RATE_1: cnt_tick = src_tick;
			STIC_RATE_10: cnt_tick = t10;
			STIC_RATE_100: cnt_tick = t100;
			STIC_RATE_1000: cnt_tick = t1000;
			default: cnt_tick = src_tick;
		endcase
	end

	// register port decode
	wire sel_addr = i_addr == `STIC_OFF_ADDR;
	wire sel_stat = i_addr == `STIC_OFF_STATUS;
	wire sel_cnt = i_addr == `STIC_OFF_COUNT;
	wire sel_mod = i_addr == `STIC_OFF_MODNUM;
	wire sel_cmd = i_addr == `STIC_OFF_CMD;
	wire cmd_clear = i_wr && sel_cmd && i_wdata[`STIC_CMD_CLEAR];
	wire cmd_disarm = i_wr && sel_cmd && i_wdata[`STIC_CMD_DISARM];
	wire cmd_arm = i_wr && sel_cmd && i_wdata[`STIC_CMD_ARM];

	logic armed_reg, counting_reg, full_reg, ovf_reg, late_reg;
	logic [DATA_W-1:0] cnt_reg;
	logic [PTR_W-1:0] ptr_reg;
	logic [PTR_W-1:0] nstops_reg;
	logic [DATA_W-1:0] mem [DEPTH];

	wire host_ok = !armed_reg;
	wire rd_cnt = i_rd && sel_cnt && host_ok;
	wire wr_addr = i_wr && sel_addr && host_ok;
	wire stop_all = cmd_clear || cmd_disarm || dis_ev;
	wire at_max = cnt_reg == `STIC_CNT_MAX;
	// valid stop only while counting and before overflow
	wire store = counting_reg && stop_ev && !at_max;
	wire last = store && ptr_reg == PTR_W'(DEPTH - 1);
	wire ovf_hit = counting_reg && at_max;

	always_ff @(posedge i_clk_sys)
	begin
		if (store)
			mem[ptr_reg] <= cnt_reg;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			armed_reg <= 1'b0;
			counting_reg <= 1'b0;
			full_reg <= 1'b0;
			ovf_reg <= 1'b0;
			late_reg <= 1'b0;
			cnt_reg <= '0;
			ptr_reg <= '0;
			nstops_reg <= '0;
		end
		else if (cmd_arm)
		begin
			armed_reg <= 1'b1;
			counting_reg <= 1'b0;
			full_reg <= 1'b0;
			ovf_reg <= 1'b0;
			late_reg <= 1'b0;
			cnt_reg <= '0;
			ptr_reg <= '0;
			nstops_reg <= '0;
		end
		else if (stop_all)
		begin
			armed_reg <= 1'b0;
			counting_reg <= 1'b0;
			cnt_reg <= '0;
			ptr_reg <= '0;
			if (cmd_clear)
			begin
				full_reg <= 1'b0;
				ovf_reg <= 1'b0;
				late_reg <= 1'b0;
				nstops_reg <= '0;
			end
		end
		else if (ovf_hit)
		begin
			armed_reg <= 1'b0;
			counting_reg <= 1'b0;
			ovf_reg <= 1'b1;
			cnt_reg <= '0;
			ptr_reg <= '0;
		end
		else if (last)
		begin
			armed_reg <= 1'b0;
			counting_reg <= 1'b0;
			full_reg <= 1'b1;
			cnt_reg <= '0;
			ptr_reg <= '0;
			nstops_reg <= '0;
		end
		else
		begin
			// late stop: overflow ended the count; flag until next arm or clear command
			if (ovf_reg && stop_ev)
				late_reg <= 1'b1;
			if (armed_reg && !counting_reg && start_ev)
				counting_reg <= 1'b1;
			if (counting_reg && cnt_tick)
				cnt_reg <= cnt_reg + 1'b1;
			if (store)
			begin
				ptr_reg <= ptr_reg + 1'b1;
				nstops_reg <= nstops_reg + 1'b1;
			end
			else if (rd_cnt)
				ptr_reg <= ptr_reg + 1'b1;
			else if (wr_addr)
				ptr_reg <= i_wdata[PTR_W-1:0];
		end
	end

	// read data one cycle after the strobe; cnt_reg has no read path
	logic [23:0] rdata_reg;
	logic q_reg, x_reg;
	wire [23:0] status_word = {late_reg, ovf_reg, full_reg, counting_reg,
		armed_reg, rate_reg, sel_ext_reg, 6'h00, nstops_reg};
	wire known = sel_addr || sel_stat || sel_cnt || sel_mod || sel_cmd;
	wire needs_idle = sel_addr || sel_cnt;
	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			rdata_reg <= 24'h000000;
			q_reg <= 1'b0;
			x_reg <= 1'b0;
		end
		else
		begin
			x_reg <= (i_rd || i_wr) && known;
			q_reg <= (i_rd || i_wr) && known && (!needs_idle || host_ok);
			// memory read lands in the output flop, not a mux after it
			if (rd_cnt)
				rdata_reg <= mem[ptr_reg];
			else if (i_rd && sel_addr && host_ok)
				rdata_reg <= {14'h0000, ptr_reg};
			else if (i_rd && sel_stat)
				rdata_reg <= status_word;
			else if (i_rd && sel_mod)
				rdata_reg <= {12'h000, MODULE_ID};
			else
				rdata_reg <= 24'h000000;
		end
	end
	assign o_rdata = rdata_reg;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			o_armed <= 1'b0;
			o_counting <= 1'b0;
		end
		else
		begin
			o_armed <= armed_reg;
			o_counting <= counting_reg;
		end
	end
	assign o_q = q_reg;
	assign o_x = x_reg;
endmodule // stic_top

// pin synchroniser: three flops, a change counts once stages two and
// three agree, so a one-sample glitch never reaches the capture logic
module stic_sync(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_pin,
	output logic o_rise
);
	logic [2:0] sync_reg;
	logic level_reg;
	logic level_next;
	wire agree = sync_reg[1] == sync_reg[2];
	assign level_next = agree ? sync_reg[2] : level_reg;
	assign o_rise = agree && sync_reg[2] && !level_reg;
	always_ff @(posedge i_clk)
		sync_reg <= {sync_reg[1:0], i_pin};
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			level_reg <= 1'b0;
		else
			level_reg <= level_next;
	end
endmodule // stic_sync

// one decade of the rate divider; moves only on an incoming tick
module stic_decade #(
	parameter int CNT_W = 4,
	parameter logic [CNT_W-1:0] LAST = CNT_W'(`STIC_DIV_TEN)
)(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_tick,
	output logic o_tick
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	wire wrap = cnt_reg == LAST;
	assign o_tick = i_tick && wrap;
	assign cnt_next = wrap ? '0 : cnt_reg + 1'b1;
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			cnt_reg <= '0;
		else if (i_tick)
			cnt_reg <= cnt_next;
	end
endmodule // stic_decade
`default_nettype wire

/* stic_properties.sv */
// port assertions for the interval counter
`timescale 1ns/1ps
`default_nettype none
module stic_chk(
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic [3:0] i_addr,
	input wire logic [23:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic o_q,
	input wire logic o_x,
	input wire logic o_armed,
	input wire logic o_counting
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	wire logic cmd = i_wr && i_addr == 4'h8;
	wire logic arm = cmd && i_wdata[2];
	wire logic dis = cmd && i_wdata[2:1] == 2'h1;
	AST_UNMAPPED: assert property (
		i_rd && i_addr == 4'h3 |=> !o_x && !o_q) else $error("bad unmapped");
	AST_KNOWN: assert property (
		i_rd && i_addr == 4'h6 |=> o_x && o_q) else $error("bad id answer");
	// armed one cycle later means the strobe saw it armed
	AST_REFUSE: assert property (
		i_rd && i_addr == 4'h2 ##1 o_armed |-> !o_q) else $error("not refused");
	AST_STATUS: assert property (
		i_rd && i_addr == 4'h1 |=> o_q) else $error("status refused");
	AST_ARM: assert property (
		arm |-> ##2 o_armed && !o_counting) else $error("arm failed");
	AST_DISARM: assert property (
		dis |-> ##2 !o_armed) else $error("disarm failed");
	AST_START: assert property (
		$rose(o_counting) |-> $past(o_armed)) else $error("count unarmed");
	AST_ARMED: assert property (
		o_counting |-> o_armed) else $error("counting unarmed");
endmodule // stic_chk
bind stic_top stic_chk u_chk(.i_clk_sys(i_clk_sys), .i_reset(i_reset),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_q(o_q), .o_x(o_x), .o_armed(o_armed), .o_counting(o_counting));
`default_nettype wire

/* stic_src.sv */
// front-panel pulse and count clock source
`timescale 1ns/1ps
`default_nettype none
module stic_src(
	input wire logic i_clk,
	output logic o_cnt_clk,
	output logic o_ext_clk,
	output logic o_start,
	output logic o_stop,
	output logic o_disarm
);
	logic [2:0] n = 3'h0;
	logic [2:0] pin = 3'h0;
	assign {o_disarm, o_stop, o_start} = pin;
	// free-running, 8 cycles a period, so 5 counts per pulse slot
	assign o_cnt_clk = n[2];
	// front-panel clock at twice the rate, 10 counts per pulse slot
	assign o_ext_clk = n[1];
	always_ff @(posedge i_clk)
		n <= n + 3'h1;
	task pulse(input int w);
		@(posedge i_clk);
		pin <= 3'h1 << w;
		repeat (4) @(posedge i_clk);
		pin <= 3'h0;
		repeat (35) @(posedge i_clk);
		#1;
	endtask
endmodule // stic_src
`default_nettype wire

/* testbench.sv */
// self-checking bench for the interval counter
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 0, rst = 1, wr = 0, rd = 0, rq, rx, cc, st, sp, ds;
	logic ce, sx = 0;
	logic [1:0] rt = 2'h0;
	logic [3:0] ad = 4'h0;
	logic [23:0] wd = 24'h0, rv, d, p;
	logic [9:0] a;
	logic arm, cnt;
	int n_fail = 0, n_compared = 0, seed = 54;
	always #2 clk = ~clk;
	stic_top uut(.i_clk_sys(clk), .i_reset(rst), .i_addr(ad), .i_wdata(wd),
		.i_wr(wr), .i_rd(rd), .o_rdata(rv), .o_q(rq), .o_x(rx),
		.i_start(st), .i_stop(sp), .i_disarm(ds), .i_clk_int(cc),
		.i_clk_ext(ce), .i_sel_ext(sx), .i_rate(rt),
		.o_armed(arm), .o_counting(cnt));
	stic_src src(.i_clk(clk), .o_cnt_clk(cc), .o_ext_clk(ce), .o_start(st),
		.o_stop(sp), .o_disarm(ds));
	// stop slots between the two stores compared at each rate
	function automatic int span(input int r);
		return r < 2 ? 1 : r == 2 ? 10 : 100;
	endfunction
	// counts over that span: 10 external edges a slot, else one tick
	function automatic logic [23:0] gain(input int r);
		return r == 0 ? 24'hA : 24'h1;
	endfunction
	// armed, counting, external clock, rate, stops so far
	function automatic logic [23:0] stat(input int r);
		return 24'h190000 | 24'(r << 17) | 24'(span(r) + 1);
	endfunction
	task chk(input string s, input logic [23:0] e, g);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask
	task wrr(input logic [3:0] x, input logic [23:0] v);
		@(posedge clk);
		wr <= 1;
		ad <= x;
		wd <= v;
		@(posedge clk);
		wr <= 0;
		#1;
	endtask
	task rdr(input logic [3:0] x);
		@(posedge clk);
		rd <= 1;
		ad <= x;
		@(posedge clk);
		rd <= 0;
		#1 d = {rq, rx} == 2'h3 ? rv : 24'h0;
	endtask
	task complete_run;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge clk);
		n_fail++;
		complete_run;
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 0;
		rdr(4'h1);
		chk("status", 24'h0, d);
		rdr(4'h3);
		chk("unmapped x", 24'h0, {23'h0, rx});
		rdr(4'h6);
		chk("id answer", 24'h3, {22'h0, rq, rx});
		chk("id top bits", 24'h0, d & 24'hFFF000);
		for (int i = 0; i < 8; i++)
		begin
			a = 10'($random(seed));
			wrr(4'h0, {14'h0, a});
			rdr(4'h2);
			rdr(4'h0);
			chk("pointer", 24'(a + 10'h1), d);
		end
		$display("test pointer done");
		wrr(4'h8, 24'h4);
		rdr(4'h2);
		chk("q armed", 24'h0, {23'h0, rq});
		src.pulse(1);
		src.pulse(0);
		src.pulse(0);
		repeat (1024) src.pulse(1);
		rdr(4'h1);
		chk("full", 24'h200000, d & 24'h3803FF);
		rdr(4'h0);
		chk("pointer", 24'h0, d);
		for (int i = 0; i < 1024; i++)
		begin
			rdr(4'h2);
			if (i > 0)
				chk("interval", p + 24'h5, d);
			p = d;
		end
		$display("test capture done");
		wrr(4'h8, 24'h4);
		src.pulse(0);
		src.pulse(1);
		wrr(4'h8, 24'h4);
		repeat (4) @(posedge clk);
		chk("counting", 24'h0, {23'h0, cnt});
		src.pulse(0);
		chk("counting", 24'h1, {23'h0, cnt});
		src.pulse(2);
		chk("armed", 24'h0, {23'h0, arm});
		src.pulse(0);
		chk("counting", 24'h0, {23'h0, cnt});
		wrr(4'h8, 24'h4);
		src.pulse(0);
		src.pulse(1);
		wrr(4'h8, 24'h2);
		rdr(4'h0);
		chk("pointer", 24'h0, d);
		$display("test disarm done");
		for (int r = 0; r < 4; r++)
		begin
			@(posedge clk);
			sx <= 1'b1;
			rt <= 2'(r);
			wrr(4'h8, 24'h4);
			src.pulse(0);
			repeat (span(r) + 1) src.pulse(1);
			rdr(4'h1);
			chk("status", stat(r), d);
			wrr(4'h8, 24'h2);
			rdr(4'h2);
			p = d;
			wrr(4'h0, 24'(span(r)));
			rdr(4'h2);
			chk("rate step", gain(r), d - p);
		end
		$display("test rate done");
		complete_run;
	end
endmodule // testbench
`default_nettype wire
